// ==== hw/btm_monitor.sv ====
// battery temperature protection and adc result monitor
// Behaviour
// - five channels of 12-bit codes; current 25/11 mA, die 1/6.82 degree steps
// - output 4 mV, battery 1.2 mV, thermistor 1.1 mV per code
// - after reset the thermistor bias is the 80 uA setting
// - at 80 uA, thermistor above 2.712 V selects 40 uA
// - at 40 uA, thermistor below 0.718 V selects 80 uA
// - discharge: cold 2.711 V at 40 uA; hot regulate 0.283, protect 0.242
// - charge at 80 uA: cold at or above 2.182, hot at or below 0.333
// - charge: current step-down set at 1.764 V, cleared at 1.437 V
// - charge: voltage step-back set at 0.393 V, cleared at 0.466 V
// - current step-down active halves the charge current
// - step-back lowers target 0.1 V; charge protection stops the charger
// - discharge protection stops and turns off the boost
// - boost restarts only on a new start event, not on recovery
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module btm_monitor
  import btm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic                   wb_ack_o,
  input  wire logic              adc_valid_i,
  input  wire logic [2:0]        adc_ch_i,
  input  wire logic [ADC_W-1:0]  adc_code_i,
  input  wire logic              boost_start_i,
  output logic                   irq_o,
  output logic                   bias_40ua_o,
  output logic                   boost_en_o,
  output logic                   boost_hot_reg_o,
  output logic                   chg_half_current_o,
  output logic                   chg_vtarget_down_o,
  output logic                   chg_stop_o
);

  // ****************************************
  // state
  // ****************************************
  btm_bias_type      bias_reg, bias_next;
  logic [ADC_W-1:0]  raw_reg [NUM_CH];
  logic [ADC_W-1:0]  raw_next [NUM_CH];
  logic [1:0]        ctrl_reg, ctrl_next;
  logic              cold_reg, cold_next;
  logic              hot_reg, hot_next;
  logic              hreg_reg, hreg_next;
  logic              boost_reg, boost_next;
  logic              ji_reg, ji_next;
  logic              jv_reg, jv_next;
  logic              stop_reg, stop_next;
  logic [NUM_EV-1:0] ist_reg, ist_next;
  logic [NUM_EV-1:0] imask_reg, imask_next;
  logic              irq_reg, irq_next;
  logic              ack_reg, ack_next;
  logic [31:0]       dat_reg, dat_next;

  // ****************************************
  // decode
  // ****************************************
  logic              req, wr, rd, ntc_smp, on80, chg_mode, trip, start;
  logic [ADC_W-1:0]  c;
  logic [NUM_EV-1:0] ev;
  logic [2:0]        ridx, sidx;
  logic [15:0]       die_val;

  function automatic logic [15:0] scale(input logic [11:0] code,
                                        input int ch);
    logic [31:0] p;
    p = {20'h00000, code} * {16'h0000, SC_NUM[ch]};
    return 16'(p / {16'h0000, SC_DEN[ch]});
  endfunction : scale

  function automatic logic [15:0] die_deg(input logic [11:0] code);
    logic [15:0] d;
    d = scale(code, 4) - DIE_OFS;
    if (!d[15] && d > DIE_MAX) begin
      d = DIE_MAX;
    end
    return d;
  endfunction : die_deg

  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  assign c        = adc_code_i;
  assign ntc_smp  = adc_valid_i && (adc_ch_i == CH_NTC);
  assign on80     = (bias_reg == BTM_BIAS_80);
  assign chg_mode = ctrl_reg[CTRL_CHG];
  assign start    = boost_start_i |
                    (wr && wb_adr_i == REG_CTRL && wb_dat_i[CTRL_GO]);
  // ntc code crossing a discharge limit under the matching bias
  assign trip     = ntc_smp & ~chg_mode &
                    ((~on80 & (c >= DIS_COLD_CODE)) |
                     (on80 & (c <= DIS_HOT_CODE)));
  // indices wrap outside their window, so each is read only in range
  assign ridx     = 3'((wb_adr_i - REG_RAW0) >> 2);
  assign sidx     = 3'((wb_adr_i - REG_SCL0) >> 2);
  assign die_val  = die_deg(raw_reg[CH_DIE]);

  // ****************************************
  // measurement and protection
  // ****************************************
  always_comb begin
    bias_next = bias_reg;
    for (int i = 0; i < NUM_CH; i++) begin
      raw_next[i] = raw_reg[i];
    end
    if (adc_valid_i && adc_ch_i < 3'(NUM_CH)) begin
      raw_next[adc_ch_i] = c;
    end
    if (ntc_smp) begin
      case (bias_reg)
        BTM_BIAS_80: begin
          if (c > BIAS_UP_CODE) begin
            bias_next = BTM_BIAS_40;
          end
        end
        BTM_BIAS_40: begin
          if (c < BIAS_DN_CODE) begin
            bias_next = BTM_BIAS_80;
          end
        end
        default: begin
          bias_next = BTM_BIAS_80;
        end
      endcase
    end
    cold_next = cold_reg;
    hot_next  = hot_reg;
    hreg_next = hreg_reg;
    if (chg_mode) begin
      cold_next = 1'b0;
      hot_next  = 1'b0;
      hreg_next = 1'b0;
    end else if (ntc_smp && !on80) begin
      cold_next = (c >= DIS_COLD_CODE);
    end else if (ntc_smp) begin
      hot_next  = (c <= DIS_HOT_CODE);
      hreg_next = (c <= DIS_HREG_CODE);
    end
    // a trip wins over a start in the same cycle
    boost_next = boost_reg;
    if (trip) begin
      boost_next = 1'b0;
    end else if (start) begin
      boost_next = 1'b1;
    end
    stop_next = stop_reg;
    ji_next   = ji_reg;
    jv_next   = jv_reg;
    if (!chg_mode) begin
      stop_next = 1'b0;
      ji_next   = 1'b0;
      jv_next   = 1'b0;
    end else if (ntc_smp && on80) begin
      stop_next = (c >= CHG_COLD_CODE) ||
                  (c <= CHG_HOT_CODE);
      if (c >= JI_SET_CODE) begin
        ji_next = 1'b1;
      end else if (c <= JI_CLR_CODE) begin
        ji_next = 1'b0;
      end
      if (c <= JV_SET_CODE) begin
        jv_next = 1'b1;
      end else if (c >= JV_CLR_CODE) begin
        jv_next = 1'b0;
      end
    end
    // step-down flags only matter while the feature is on
    if (!ctrl_reg[CTRL_JEN]) begin
      ji_next = 1'b0;
      jv_next = 1'b0;
    end
  end

  // ****************************************
  // register bus and interrupts
  // ****************************************
  always_comb begin
    ev = {hreg_next & ~hreg_reg, ji_next ^ ji_reg, jv_next ^ jv_reg,
          stop_next & ~stop_reg, trip & boost_reg,
          bias_next != bias_reg};
    ctrl_next  = ctrl_reg;
    imask_next = imask_reg;
    ist_next   = ist_reg;
    if (wr && wb_adr_i == REG_CTRL) begin
      ctrl_next = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == REG_IMASK) begin
      imask_next = wb_dat_i[NUM_EV-1:0];
    end
    if (wr && wb_adr_i == REG_ISTAT) begin
      ist_next = ist_reg & ~wb_dat_i[NUM_EV-1:0];
    end
    // set beats a write-one clear landing in the same cycle
    ist_next = ist_next | ev;
    irq_next = |(ist_next & imask_next);
    ack_next = req;
    dat_next = 32'h00000000;
    if (rd) begin
      case (wb_adr_i)
        REG_CTRL:  dat_next = {30'h00000000, ctrl_reg};
        REG_STAT:  dat_next = {25'h0000000, bias_reg == BTM_BIAS_40,
                               boost_reg, hreg_reg, cold_reg | hot_reg,
                               stop_reg, jv_reg, ji_reg};
        REG_ISTAT: dat_next = {26'h0000000, ist_reg};
        REG_IMASK: dat_next = {26'h0000000, imask_reg};
        REG_VDROP: dat_next = {16'h0000, jv_reg ? VDROP_MV : 16'h0000};
        default: begin
          if (wb_adr_i[1:0] == 2'h0 && wb_adr_i >= REG_RAW0 &&
              wb_adr_i < REG_SCL0) begin
            dat_next = {20'h00000, raw_reg[ridx]};
          end else if (wb_adr_i[1:0] == 2'h0 && wb_adr_i >= REG_SCL0 &&
                       wb_adr_i < REG_VDROP) begin
            // die result is signed, the others plain magnitudes
            dat_next = (sidx == CH_DIE) ?
              {{16{die_val[15]}}, die_val} :
              {16'h0000, scale(raw_reg[sidx], int'(sidx))};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_reg  <= BTM_BIAS_80;
      for (int i = 0; i < NUM_CH; i++) begin
        raw_reg[i] <= 12'h000;
      end
      ctrl_reg  <= CTRL_RST;
      cold_reg  <= 1'b0;
      hot_reg   <= 1'b0;
      hreg_reg  <= 1'b0;
      boost_reg <= 1'b0;
      ji_reg    <= 1'b0;
      jv_reg    <= 1'b0;
      stop_reg  <= 1'b0;
      ist_reg   <= 6'h00;
      imask_reg <= 6'h00;
      irq_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h00000000;
    end else begin
      bias_reg  <= bias_next;
      for (int i = 0; i < NUM_CH; i++) begin
        raw_reg[i] <= raw_next[i];
      end
      ctrl_reg  <= ctrl_next;
      cold_reg  <= cold_next;
      hot_reg   <= hot_next;
      hreg_reg  <= hreg_next;
      boost_reg <= boost_next;
      ji_reg    <= ji_next;
      jv_reg    <= jv_next;
      stop_reg  <= stop_next;
      ist_reg   <= ist_next;
      imask_reg <= imask_next;
      irq_reg   <= irq_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_dat_o           = dat_reg;
  assign wb_ack_o           = ack_reg;
  assign irq_o              = irq_reg;
  assign bias_40ua_o        = bias_reg[1];
  assign boost_en_o         = boost_reg;
  assign boost_hot_reg_o    = hreg_reg;
  assign chg_half_current_o = ji_reg;
  assign chg_vtarget_down_o = jv_reg;
  assign chg_stop_o         = stop_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_bias_reset: assert property (
    $fell(rst_i) |-> !bias_40ua_o)
    else $error("bias not 80 uA after reset");
  chk_bias_up: assert property (
    ntc_smp && !bias_40ua_o && c > BIAS_UP_CODE |=> bias_40ua_o)
    else $error("bias did not move to 40 uA");
  chk_bias_down: assert property (
    ntc_smp && bias_40ua_o && c < BIAS_DN_CODE |=> !bias_40ua_o)
    else $error("bias did not return to 80 uA");
  chk_bias_hold: assert property (
    !ntc_smp || (c >= BIAS_DN_CODE && c <= BIAS_UP_CODE)
    |=> $stable(bias_40ua_o))
    else $error("bias moved between switch points");
  chk_boost_trip: assert property (
    trip |=> !boost_en_o ##1 (!boost_en_o || $past(start)))
    else $error("boost not stopped on protection");
  chk_no_restart: assert property (
    !boost_en_o && !start |=> !boost_en_o)
    else $error("boost restarted without a start");
  chk_jeita_cur: assert property (
    chg_mode && ctrl_reg[CTRL_JEN] && ntc_smp && on80 &&
    c >= JI_SET_CODE |=> chg_half_current_o)
    else $error("current step-down not requested");
  chk_jeita_keep: assert property (
    chg_half_current_o && chg_mode && ctrl_reg[CTRL_JEN] &&
    !(ntc_smp && on80 && c <= JI_CLR_CODE) && !wr
    |=> chg_half_current_o)
    else $error("current step-down dropped early");
  chk_jeita_volt: assert property (
    chg_mode && ctrl_reg[CTRL_JEN] && ntc_smp && on80 &&
    c <= JV_SET_CODE |=> chg_vtarget_down_o)
    else $error("voltage step-back not requested");
  chk_chg_stop: assert property (
    chg_mode && ntc_smp && on80 && c <= CHG_HOT_CODE |=> chg_stop_o)
    else $error("charger not stopped when hot");
  chk_wb_ack: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle answer");
  chk_hot_regulate: assert property (
    !chg_mode && ntc_smp && on80 && c <= DIS_HREG_CODE |=> boost_hot_reg_o)
    else $error("hot regulation not raised");
  chk_chg_cold: assert property (
    chg_mode && ntc_smp && on80 && c >= CHG_COLD_CODE |=> chg_stop_o)
    else $error("charger not stopped when cold");
  chk_bias_gate: assert property (
    chg_mode && ntc_smp && !on80 |=> $stable(chg_stop_o))
    else $error("charge compare made under 40 uA");
  chk_irq_level: assert property (
    irq_o == |(ist_reg & imask_reg))
    else $error("irq out of step with status");
  chk_sticky_ev: assert property (
    ist_reg[0] && !(wr && wb_adr_i == REG_ISTAT && wb_dat_i[0])
    |=> ist_reg[0])
    else $error("status bit lost without a clear");

endmodule : btm_monitor

// ==== hw/btm_pkg.sv ====
// constants for the battery temperature and adc monitor
package btm_pkg;

  // ****************************************
  // converter and thermistor channel
  // ****************************************
  localparam int ADC_W       = 12;
  localparam int NTC_STEP_UV = 1100;

  function automatic logic [11:0] mv_to_code(input int mv);
    return 12'(mv * 1000 / NTC_STEP_UV);
  endfunction : mv_to_code

  localparam logic [11:0] BIAS_UP_CODE  = mv_to_code(2712);
  localparam logic [11:0] BIAS_DN_CODE  = mv_to_code(718);
  localparam logic [11:0] DIS_COLD_CODE = mv_to_code(2711);
  localparam logic [11:0] DIS_HREG_CODE = mv_to_code(283);
  localparam logic [11:0] DIS_HOT_CODE  = mv_to_code(242);
  localparam logic [11:0] CHG_COLD_CODE = mv_to_code(2182);
  localparam logic [11:0] CHG_HOT_CODE  = mv_to_code(333);
  localparam logic [11:0] JI_SET_CODE   = mv_to_code(1764);
  localparam logic [11:0] JI_CLR_CODE   = mv_to_code(1437);
  localparam logic [11:0] JV_SET_CODE   = mv_to_code(393);
  localparam logic [11:0] JV_CLR_CODE   = mv_to_code(466);
  localparam logic [15:0] VDROP_MV      = 16'h0064;

  // ****************************************
  // channels and scaling (value = code*num/den)
  // ****************************************
  localparam logic [2:0]  CH_OUTPUT_VOLTAGE_SENSE = 3'h0;
  localparam logic [2:0]  CH_OUTPUT_CURRENT_SENSE = 3'h1;
  localparam logic [2:0]  CH_VBAT = 3'h2;
  localparam logic [2:0]  CH_NTC  = 3'h3;
  localparam logic [2:0]  CH_DIE  = 3'h4;
  localparam int          NUM_CH  = 5;
  localparam logic [15:0] SC_NUM [NUM_CH] = '{16'h0004, 16'h0019,
    16'h000c, 16'h000b, 16'h0064};
  localparam logic [15:0] SC_DEN [NUM_CH] = '{16'h0001, 16'h000b,
    16'h000a, 16'h000a, 16'h02aa};
  localparam logic [15:0] DIE_OFS = 16'h0064;
  localparam logic [15:0] DIE_MAX = 16'h00c8;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_ISTAT = 8'h08;
  localparam logic [7:0] REG_IMASK = 8'h0c;
  localparam logic [7:0] REG_RAW0  = 8'h10;
  localparam logic [7:0] REG_SCL0  = 8'h24;
  localparam logic [7:0] REG_VDROP = 8'h38;
  localparam int CTRL_CHG = 0;
  localparam int CTRL_JEN = 1;
  localparam int CTRL_GO  = 2;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int NUM_EV = 6;

  typedef enum logic [1:0] {
    BTM_BIAS_80 = 2'b01,
    BTM_BIAS_40 = 2'b10
  } btm_bias_type;

endpackage : btm_pkg

// ==== testbench/btm_sense_model.sv ====
// far-side model: thermistor and analog sense channels as converter samples
`timescale 1ns/1ps
module btm_sense_model (
  input  wire logic        clk_i,
  output logic             valid_o,
  output logic [2:0]       ch_o,
  output logic [11:0]      code_o
);
  // ****************************************
  // sample delivery
  // ****************************************
  initial begin
    valid_o = 1'b0;
    ch_o    = 3'h7;
    code_o  = 12'h000;
  end

  // idle code is inverted so a stale value never passes as a sample
  task automatic put(input logic [2:0] c, input logic [11:0] d,
                     input int gap);
    repeat (gap) @(posedge clk_i);
    valid_o <= 1'b1;
    ch_o    <= c;
    code_o  <= d;
    @(posedge clk_i);
    valid_o <= 1'b0;
    code_o  <= ~d;
    @(posedge clk_i);
  endtask : put

  // thermistor at 1.1 mV per code, truncated
  task automatic ntc(input int mv, input int gap);
    put(3'h3, 12'(mv * 10 / 11), gap);
  endtask : ntc
endmodule : btm_sense_model

// ==== testbench/btm_monitor_tb.sv ====
// self-checking bench for the temperature and adc monitor
`timescale 1ns/1ps
module btm_monitor_tb;
  import btm_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic        we;
  logic [3:0]  sel;
  logic        cyc;
  logic        stb;
  logic        start;
  logic [31:0] rdat;
  logic        ack;
  logic        av;
  logic [2:0]  ach;
  logic [11:0] acode;
  logic [6:0]  outs;
  logic [38:0] exp_q [$];
  int          fails;
  int          total_checks;
  int          seed;
  int          cycles;

  btm_monitor i_btm_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .adc_valid_i(av), .adc_ch_i(ach),
    .adc_code_i(acode), .boost_start_i(start), .irq_o(outs[6]),
    .bias_40ua_o(outs[5]), .boost_en_o(outs[4]),
    .boost_hot_reg_o(outs[3]), .chg_half_current_o(outs[2]),
    .chg_vtarget_down_o(outs[1]), .chg_stop_o(outs[0]));

  btm_sense_model i_btm_sense_model (
    .clk_i(clk_i), .valid_o(av), .ch_o(ach), .code_o(acode));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [38:0] seen, input logic [38:0] expv);
    total_checks++;
    if (seen !== expv) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, expv);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    adr  <= a;
    we   <= w;
    wdat <= d;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [6:0] o);
    exp_q.push_back({o, d});
    wb(a, 1'b0, 32'h0);
  endtask : rd

  // one thermistor sample, then status and pins
  task automatic step(input int mv, input logic [31:0] s,
                      input logic [6:0] o);
    i_btm_sense_model.ntc(mv, $unsigned($random(seed)) % 3);
    rd(REG_STAT, s, o);
  endtask : step

  task automatic end_of_test;
    // a note left in the queue is an answer that never came
    if (exp_q.size() != 0) begin
      fails++;
    end
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ****************************************
  // clock, checker, timeout
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk({outs, rdat}, exp_q.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      end_of_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin : main
    logic [2:0]  c;
    logic [11:0] d;
    logic [31:0] e;
    seed = 32'h45e8;
    rst_i = 1'b1;
    {adr, wdat, we, cyc, stb, start} = '0;
    sel = 4'hf;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG_STAT, 32'h0, 7'h00);
    rd(8'hfc, 32'h0, 7'h00);
    wb(REG_IMASK, 1'b1, 32'h3f);
    wb(REG_CTRL, 1'b1, 32'h6);
    rd(REG_STAT, 32'h20, 7'h10);
    // a write without the low byte select must leave the mask alone
    sel <= 4'he;
    wb(REG_IMASK, 1'b1, 32'h0);
    sel <= 4'hf;
    rd(REG_IMASK, 32'h3f, 7'h10);
    step(283, 32'h30, 7'h58);
    rd(REG_ISTAT, 32'h20, 7'h58);
    step(242, 32'h18, 7'h48);
    step(1000, 32'h00, 7'h40);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    wb(REG_ISTAT, 1'b1, 32'h3f);
    rd(REG_STAT, 32'h20, 7'h10);
    step(2712, 32'h20, 7'h10);
    step(2713, 32'h60, 7'h70);
    step(3000, 32'h48, 7'h60);
    step(718, 32'h40, 7'h60);
    step(717, 32'h00, 7'h40);
    wb(REG_ISTAT, 1'b1, 32'h3f);
    wb(REG_CTRL, 1'b1, 32'h3);
    step(2182, 32'h05, 7'h45);
    step(1500, 32'h01, 7'h44);
    step(1437, 32'h00, 7'h40);
    wb(REG_ISTAT, 1'b1, 32'h3f);
    step(466, 32'h00, 7'h00);
    step(393, 32'h02, 7'h42);
    rd(REG_VDROP, 32'h64, 7'h42);
    step(420, 32'h02, 7'h42);
    step(333, 32'h06, 7'h43);
    step(466, 32'h00, 7'h40);
    rd(REG_VDROP, 32'h0, 7'h40);
    // move to 40 uA with flags up, then reset in mid-run
    i_btm_sense_model.ntc(3000, 0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG_STAT, 32'h0, 7'h00);
    i_btm_sense_model.ntc(1000, 0);
    rd(REG_RAW0 + 8'h0c, 32'd909, 7'h00);
    rd(REG_SCL0 + 8'h0c, 32'd999, 7'h00);
    // random codes on the linear channels
    repeat (6) begin
      c = 3'($unsigned($random(seed)) % 3);
      d = 12'($random(seed));
      e = (c == 3'h0) ? d * 4 : (c == 3'h1) ? d * 25 / 11 : d * 12 / 10;
      i_btm_sense_model.put(c, d, 1);
      rd(REG_RAW0 + 8'(4 * c), {20'h0, d}, 7'h00);
      rd(REG_SCL0 + 8'(4 * c), e, 7'h00);
    end
    i_btm_sense_model.put(3'h4, 12'd1364, 0);
    rd(REG_SCL0 + 8'h10, 32'h64, 7'h00);
    i_btm_sense_model.put(3'h4, 12'h000, 0);
    rd(REG_SCL0 + 8'h10, 32'hffffff9c, 7'h00);
    i_btm_sense_model.put(3'h4, 12'hfff, 0);
    rd(REG_SCL0 + 8'h10, 32'h000000c8, 7'h00);
    repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule : btm_monitor_tb
